// *** acf_pkg.sv ***
// package: register map, field positions, reset values, timing for the converter setup and event block
// assumes: a 10 MHz core clock and a 32-bit classic wishbone slave port
package acf_pkg;

   // ********************************
   // register offsets (byte address)
   // ********************************
   localparam logic [7:0] ADDR_SETUP  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0c;
   localparam logic [7:0] ADDR_RAW    = 8'h10;
   localparam logic [7:0] ADDR_RESULT = 8'h14;
   localparam logic [7:0] ADDR_OFFSET = 8'h18;
   localparam logic [7:0] ADDR_CTRL   = 8'h1c;
   localparam logic [7:0] ADDR_UPPER  = 8'h24;
   localparam logic [7:0] ADDR_LOWER  = 8'h28;

   // ********************************
   // field positions
   // ********************************
   localparam int ATTEN_LSB   = 8;
   localparam int REPEAT_BIT  = 11;
   localparam int BYPASS_BIT  = 18;
   localparam int RATE_BIT    = 20;
   localparam int MICOUT_BIT  = 22;
   localparam int CAL_BIT     = 0;
   localparam int EOC_BIT     = 2;
   localparam int WIN_BIT     = 3;
   localparam int CMP_EN_BIT  = 0;
   localparam int SETTLED_BIT = 8;

   // ********************************
   // reset values
   // ********************************
   localparam logic [3:0]  MASK_RST  = 4'hf;
   localparam logic [31:0] UPPER_RST = 32'h0fff_ffff;
   localparam logic [31:0] LOWER_RST = 32'h0000_0000;

   // ********************************
   // settle counts and microphone clock timing
   // ********************************
   localparam logic [3:0] SETTLE_FILTERED = 4'ha;
   localparam logic [3:0] SETTLE_BYPASSED = 4'h3;
   localparam int CLK_HZ      = 10_000_000;
   localparam int MIC_FAST_HZ = 1_600_000;
   localparam int MIC_SLOW_HZ = 800_000;
   localparam int FAST_HALF   = CLK_HZ / (2 * MIC_FAST_HZ);
   localparam int SLOW_HALF   = CLK_HZ / (2 * MIC_SLOW_HZ);

endpackage

// *** acf_mic_if.sv ***
// interface: control and pin signals between the setup block and the microphone clock generator
// assumes: both ends on CORE_CLK
`timescale 1ns/1ps
interface acf_mic_if;
   logic run;
   logic slow;
   logic clk_o;
   logic oe_n;
   modport ctl (output run, output slow, input clk_o, input oe_n);
   modport gen (input run, input slow, output clk_o, output oe_n);
endinterface

// *** acf_mic_clk.sv ***
// module: microphone clock divider driving a gpio with enable
// assumes: CORE_CLK at CLK_HZ, synchronous active-high reset
`timescale 1ns/1ps
module acf_mic_clk
   import acf_pkg::*;
(
   // clock and reset
   input  wire logic CORE_CLK,
   input  wire logic RST,
   // control and pin
   acf_mic_if.gen    mic
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       clk;
      logic       oe_n;
   } acf_mic_s;

   localparam logic [7:0] FAST_TOP = 8'(FAST_HALF - 1);
   localparam logic [7:0] SLOW_TOP = 8'(SLOW_HALF - 1);

   acf_mic_s st_ff;
   acf_mic_s nxt_st;
   logic [7:0] top;

   // ********************************
   // divider
   // ********************************
   // 10 MHz cannot reach 1.6 MHz exactly; half periods round down
   always_comb begin
      nxt_st = st_ff;
      top = mic.slow ? SLOW_TOP : FAST_TOP;
      if (!mic.run) begin
         nxt_st.cnt  = 8'h00;
         nxt_st.clk  = 1'b0;
         nxt_st.oe_n = 1'b1;
      end else begin
         nxt_st.oe_n = 1'b0;
         if (st_ff.cnt >= top) begin
            nxt_st.cnt = 8'h00;
            nxt_st.clk = ~st_ff.clk;
         end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_ff <= '{cnt: 8'h00, clk: 1'b0, oe_n: 1'b1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mic.clk_o = st_ff.clk;
   assign mic.oe_n  = st_ff.oe_n;

endmodule

// *** acf_top.sv ***
// module: converter setup register, result placement, event flags and interrupt, wishbone slave
// assumes: converter events and values arrive on CORE_CLK as one-cycle pulses with data
//
// Notes on behaviour
// - attenuator field bits 9:8: 01b gives 6.02 dB, 10b gives 9.54 dB
// - setup bit 11: 0 single conversion per start, 1 continuous conversions
// - setup bit 18 set bypasses the decimation filter for faster conversion
// - filter in path: result and offset in upper halves; discard first ten samples
// - filter bypassed: result and offset in lower halves; discard first three samples
// - setup bit 20 selects microphone clock 1.6 MHz (0) or 0.8 MHz (1)
// - setup bit 22 drives microphone clock on gpio; 0 leaves it undriven
// - status bit 0 sets on calibration done, clears on status read
// - status bit 2 sets on conversion done, clears on status read
// - with comparator on, status bit 3 shows value inside window
// - window flag re-evaluated each end of conversion while comparator on, cleared on read
// - mask bit 0 gates calibration interrupt, 0 enables, resets to 1
// - mask bit 2 gates conversion interrupt, 0 enables, resets to 1
// - mask bit 3 gates window interrupt, 0 enables, resets to 1
// - raw register shows the three flags in bits 0, 2, 3; read clears
// - window comparator works only while its enable bit is 1
`timescale 1ns/1ps
module acf_top
   import acf_pkg::*;
#(
   parameter int VAL_W = 16
)
(
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RST,
   // wishbone slave
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [7:0]        WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic      [31:0]       WB_DAT_O,
   output logic                   WB_ACK_O,
   // converter events
   input  wire logic              CAL_DONE,
   input  wire logic [VAL_W-1:0]  CAL_VALUE,
   input  wire logic              CONV_DONE,
   input  wire logic [VAL_W-1:0]  CONV_VALUE,
   // converter control
   output logic      [1:0]        ATTEN_SELECT,
   output logic                   REPEAT_CONVERSION,
   output logic                   FILTER_BYPASS,
   // microphone clock pin
   output logic                   MIC_CLK_O,
   output logic                   MIC_CLK_OE_N,
   // interrupt
   output logic                   ADC_IRQ
);

   // ********************************
   // state
   // ********************************
   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic [1:0]  atten;
      logic        rep;
      logic        byp;
      logic        rate;
      logic        micout;
      logic        cmp_en;
      logic [31:0] upper;
      logic [31:0] lower;
      logic [31:0] result;
      logic [31:0] offset;
      logic [3:0]  mask;
      logic        cal_f;
      logic        eoc_f;
      logic        win_f;
      logic [3:0]  settle;
   } acf_state_s;

   acf_state_s st_ff;
   acf_state_s nxt_st;

   acf_mic_if mic_bus ();

   logic        req;
   logic        wr;
   logic        rd;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] flags;
   logic [31:0] setup_rd;
   logic [3:0]  settle_need;
   logic        in_window;
   logic signed [31:0] sval;

   // ********************************
   // bus decode
   // ********************************
   assign req = WB_CYC_I & WB_STB_I & ~st_ff.ack;
   assign wr  = req & WB_WE_I;
   assign rd  = req & ~WB_WE_I;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
      end
   end

   // ********************************
   // derived views
   // ********************************
   assign flags = {28'h000_0000, st_ff.win_f, st_ff.eoc_f, 1'b0, st_ff.cal_f};

   always_comb begin
      setup_rd = 32'h0000_0000;
      setup_rd[ATTEN_LSB +: 2] = st_ff.atten;
      setup_rd[REPEAT_BIT]     = st_ff.rep;
      setup_rd[BYPASS_BIT]     = st_ff.byp;
      setup_rd[RATE_BIT]       = st_ff.rate;
      setup_rd[MICOUT_BIT]     = st_ff.micout;
   end

   // samples to discard depend on the filter path
   assign settle_need = st_ff.byp ? SETTLE_BYPASSED : SETTLE_FILTERED;

   // signed compare of the fresh sample against both limits
   assign sval = 32'(signed'(CONV_VALUE));
   assign in_window = (sval <= signed'(st_ff.upper)) &&
                      (sval >= signed'(st_ff.lower));

   // ********************************
   // next state
   // ********************************
   always_comb begin
      nxt_st = st_ff;
      wval   = 32'h0000_0000;

      // ack pulses one cycle after the request, then drops
      nxt_st.ack = req;

      // read data, unmapped addresses read zero
      if (rd) begin
         unique case (WB_ADR_I)
            ADDR_SETUP:  nxt_st.rdat = setup_rd;
            ADDR_STATUS: nxt_st.rdat = flags & ~{28'h000_0000, st_ff.mask};
            ADDR_MASK:   nxt_st.rdat = {28'h000_0000, st_ff.mask};
            ADDR_RAW:    nxt_st.rdat = flags;
            ADDR_RESULT: nxt_st.rdat = st_ff.result;
            ADDR_OFFSET: nxt_st.rdat = st_ff.offset;
            ADDR_CTRL: begin
               nxt_st.rdat = 32'h0000_0000;
               nxt_st.rdat[CMP_EN_BIT]  = st_ff.cmp_en;
               nxt_st.rdat[SETTLED_BIT] = (st_ff.settle >= settle_need);
            end
            ADDR_UPPER:  nxt_st.rdat = st_ff.upper;
            ADDR_LOWER:  nxt_st.rdat = st_ff.lower;
            default:     nxt_st.rdat = 32'h0000_0000;
         endcase
      end

      // register writes, honouring byte lanes
      if (wr) begin
         unique case (WB_ADR_I)
            ADDR_SETUP: begin
               wval = (setup_rd & ~wmask) | (WB_DAT_I & wmask);
               nxt_st.atten  = wval[ATTEN_LSB +: 2];
               nxt_st.rep    = wval[REPEAT_BIT];
               nxt_st.byp    = wval[BYPASS_BIT];
               nxt_st.rate   = wval[RATE_BIT];
               nxt_st.micout = wval[MICOUT_BIT];
               // a mode change restarts the discard count unless a conversion ends in the same cycle with the count below 15
               if (wval[BYPASS_BIT] != st_ff.byp ||
                   wval[REPEAT_BIT] != st_ff.rep) begin
                  nxt_st.settle = 4'h0;
               end
            end
            ADDR_MASK: begin
               if (WB_SEL_I[0]) begin
                  nxt_st.mask = WB_DAT_I[3:0];
               end
            end
            ADDR_CTRL: begin
               if (WB_SEL_I[0]) begin
                  nxt_st.cmp_en = WB_DAT_I[CMP_EN_BIT];
               end
            end
            ADDR_UPPER: begin
               nxt_st.upper = (st_ff.upper & ~wmask) | (WB_DAT_I & wmask);
            end
            ADDR_LOWER: begin
               nxt_st.lower = (st_ff.lower & ~wmask) | (WB_DAT_I & wmask);
            end
            default: begin
               nxt_st.rdat = st_ff.rdat;
            end
         endcase
      end

      // read of status or raw clears all flags; events below win
      if (rd && (WB_ADR_I == ADDR_STATUS || WB_ADR_I == ADDR_RAW)) begin
         nxt_st.cal_f = 1'b0;
         nxt_st.eoc_f = 1'b0;
         nxt_st.win_f = 1'b0;
      end

      // calibration lands in the half matching the filter path
      if (CAL_DONE) begin
         nxt_st.cal_f = 1'b1;
         if (st_ff.byp) begin
            nxt_st.offset = {16'h0000, 16'(CAL_VALUE)};
         end else begin
            nxt_st.offset = {16'(CAL_VALUE), 16'h0000};
         end
      end

      // conversion result placement and window re-evaluation
      if (CONV_DONE) begin
         nxt_st.eoc_f = 1'b1;
         if (st_ff.byp) begin
            nxt_st.result = {16'h0000, 16'(CONV_VALUE)};
         end else begin
            nxt_st.result = {16'(CONV_VALUE), 16'h0000};
         end
         if (st_ff.cmp_en) begin
            nxt_st.win_f = in_window;
         end
         if (st_ff.settle != 4'hf) begin
            nxt_st.settle = st_ff.settle + 4'h1;
         end
      end
   end

   // ********************************
   // registers
   // ********************************
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_ff <= '{
            ack:    1'b0,
            rdat:   32'h0000_0000,
            atten:  2'h0,
            rep:    1'b0,
            byp:    1'b0,
            rate:   1'b0,
            micout: 1'b0,
            cmp_en: 1'b0,
            upper:  UPPER_RST,
            lower:  LOWER_RST,
            result: 32'h0000_0000,
            offset: 32'h0000_0000,
            mask:   MASK_RST,
            cal_f:  1'b0,
            eoc_f:  1'b0,
            win_f:  1'b0,
            settle: 4'h0
         };
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ********************************
   // microphone clock
   // ********************************
   assign mic_bus.run  = st_ff.micout;
   assign mic_bus.slow = st_ff.rate;

   acf_mic_clk u_mic (
      .CORE_CLK (CORE_CLK),
      .RST      (RST),
      .mic      (mic_bus.gen)
   );

   // ********************************
   // outputs
   // ********************************
   assign WB_ACK_O          = st_ff.ack;
   assign WB_DAT_O          = st_ff.rdat;
   assign ATTEN_SELECT      = st_ff.atten;
   assign REPEAT_CONVERSION = st_ff.rep;
   assign FILTER_BYPASS     = st_ff.byp;
   assign MIC_CLK_O         = mic_bus.clk_o;
   assign MIC_CLK_OE_N      = mic_bus.oe_n;

   // masked-enable sum of the three flags
   assign ADC_IRQ = |(flags[3:0] & ~st_ff.mask);

endmodule

// *** acf_top_chk.sv ***
// checker: bus, pin and interrupt properties of acf_top
// assumes: one clock, synchronous reset, bound to acf_top
`timescale 1ns/1ps
module acf_top_chk
   import acf_pkg::*;
#(
   parameter int VAL_W = 16
)
(
   // clock, reset and wishbone
   input wire logic             CORE_CLK,
   input wire logic             RST,
   input wire logic             WB_CYC_I,
   input wire logic             WB_STB_I,
   input wire logic             WB_WE_I,
   input wire logic [7:0]       WB_ADR_I,
   input wire logic [3:0]       WB_SEL_I,
   input wire logic [31:0]      WB_DAT_I,
   input wire logic [31:0]      WB_DAT_O,
   input wire logic             WB_ACK_O,
   // converter, pins and interrupt
   input wire logic             CAL_DONE,
   input wire logic [VAL_W-1:0] CAL_VALUE,
   input wire logic             CONV_DONE,
   input wire logic [VAL_W-1:0] CONV_VALUE,
   input wire logic [1:0]       ATTEN_SELECT,
   input wire logic             REPEAT_CONVERSION,
   input wire logic             FILTER_BYPASS,
   input wire logic             MIC_CLK_O,
   input wire logic             MIC_CLK_OE_N,
   input wire logic             ADC_IRQ
);
   // ****
   // properties
   // ****
   logic wr_setup;
   logic rd_clr;
   assign wr_setup = WB_ACK_O && WB_WE_I && WB_ADR_I == ADDR_SETUP && WB_SEL_I == 4'hf;
   assign rd_clr = WB_ACK_O && !WB_WE_I && (WB_ADR_I == ADDR_STATUS || WB_ADR_I == ADDR_RAW);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
   a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
   a_setup_pins: assert property (wr_setup |=> ATTEN_SELECT == $past(WB_DAT_I[9:8])
      && REPEAT_CONVERSION == $past(WB_DAT_I[REPEAT_BIT]) && FILTER_BYPASS == $past(WB_DAT_I[BYPASS_BIT]))
      else $error("setup pins wrong");
   a_mic_off: assert property (wr_setup && !WB_DAT_I[MICOUT_BIT] |-> ##[1:2] MIC_CLK_OE_N)
      else $error("mic pin still driven");
   a_mic_on: assert property (wr_setup && WB_DAT_I[MICOUT_BIT] |-> ##[1:2] !MIC_CLK_OE_N)
      else $error("mic pin not driven");
   a_mic_quiet: assert property (MIC_CLK_OE_N && $past(MIC_CLK_OE_N) |-> !MIC_CLK_O)
      else $error("mic clock toggles while off");
   a_mic_half: assert property ($rose(MIC_CLK_O) |-> (MIC_CLK_O || MIC_CLK_OE_N)[*3])
      else $error("mic half period short");
   a_irq_cause: assert property ($rose(ADC_IRQ) |-> $past(CAL_DONE) || $past(CONV_DONE) || WB_ACK_O)
      else $error("irq without cause");
   a_read_clear: assert property (rd_clr && !$past(CAL_DONE) && !$past(CONV_DONE) |-> !ADC_IRQ)
      else $error("irq after clearing read");
   a_reset_quiet: assert property (@(posedge CORE_CLK) disable iff (1'b0) RST |=> !ADC_IRQ && MIC_CLK_OE_N)
      else $error("outputs active after reset");
   cover property (wr_setup);
   cover property ($rose(ADC_IRQ));
   cover property ($rose(MIC_CLK_O));
endmodule
bind acf_top acf_top_chk #(.VAL_W(VAL_W)) u_chk (
   .CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .CAL_DONE(CAL_DONE), .CAL_VALUE(CAL_VALUE), .CONV_DONE(CONV_DONE), .CONV_VALUE(CONV_VALUE),
   .ATTEN_SELECT(ATTEN_SELECT), .REPEAT_CONVERSION(REPEAT_CONVERSION), .FILTER_BYPASS(FILTER_BYPASS),
   .MIC_CLK_O(MIC_CLK_O), .MIC_CLK_OE_N(MIC_CLK_OE_N), .ADC_IRQ(ADC_IRQ));

// *** acf_top_test.sv ***
// testbench: registers, events, interrupt and mic clock of acf_top
// assumes: acf_pkg and the bound checker compiled first
`timescale 1ns/1ps
module acf_top_test;
   import acf_pkg::*;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, cal = 0, conv = 0;
   logic [7:0]  adr = '0;
   logic [3:0]  sel = '0;
   logic [31:0] wdat = '0, rdat, q, setup;
   logic [15:0] cval = '0, vval = '0, v;
   logic [1:0]  atten;
   logic        ack, rep, byp, mclk, moe_n, irq;
   int          num_errors = 0, compares = 0, n;
   int          flg = 0, msk = 15, up = 0, lo = 0, en = 0, byp_m = 0;
   int          tbl[4] = '{100, 101, -50, -51};
   always #50 clk = ~clk;
   acf_top #(.VAL_W(16)) dut (
      .CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CAL_DONE(cal), .CAL_VALUE(cval), .CONV_DONE(conv),
      .CONV_VALUE(vval), .ATTEN_SELECT(atten), .REPEAT_CONVERSION(rep), .FILTER_BYPASS(byp),
      .MIC_CLK_O(mclk), .MIC_CLK_OE_N(moe_n), .ADC_IRQ(irq));
   // ****
   // tasks
   // ****
   task automatic stop_test;
      if (num_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t word %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t pin %b exp %b", $time, got, exp);
      end
   endtask
   // waits for ack however long it takes; the watchdog ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (!w && (a == ADDR_STATUS || a == ADDR_RAW)) flg = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic ev(input logic c, input logic [15:0] x);
      int sv;
      sv = $signed(x);
      @(posedge clk);
      cal <= c;
      conv <= !c;
      cval <= x;
      vval <= x;
      @(posedge clk);
      cal <= 1'b0;
      conv <= 1'b0;
      flg |= c ? 1 : 4;
      if (!c && en != 0) flg = (sv >= lo && sv <= up) ? flg | 8 : flg & ~8;
   endtask
   function automatic logic [31:0] pl(input logic [15:0] x);
      return byp_m != 0 ? {16'h0000, x} : {x, 16'h0000};
   endfunction
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      stop_test;
   end
   // ****
   // sequence
   // ****
   initial begin
      void'($urandom(32'h5774_673b));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_MASK, 32'h0000_000f);
      rd(ADDR_STATUS, 32'h0000_0000);
      rd(ADDR_UPPER, UPPER_RST);
      rd(ADDR_CTRL, 32'h0000_0000);
      chk_pin({moe_n, irq}, 2'b10);
      wb(1'b1, 8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         setup = ($urandom & 32'h0014_0800) | (32'(i) << ATTEN_LSB);
         wb(1'b1, ADDR_SETUP, setup);
         rd(ADDR_SETUP, setup);
         chk_pin(atten, 2'(i));
         chk_pin({rep, byp}, {setup[REPEAT_BIT], setup[BYPASS_BIT]});
      end
      for (int b = 0; b < 2; b++) begin
         byp_m = b;
         wb(1'b1, ADDR_SETUP, 32'(b) << BYPASS_BIT);
         v = 16'($urandom);
         ev(1'b1, v);
         rd(ADDR_OFFSET, pl(v));
         ev(1'b0, ~v);
         rd(ADDR_RESULT, pl(~v));
         rd(ADDR_RAW, flg);
         rd(ADDR_STATUS, 32'h0000_0000);
      end
      wb(1'b1, ADDR_RESULT, 32'hffff_ffff);
      rd(ADDR_RESULT, pl(~v));
      wb(1'b1, ADDR_MASK, 32'h0000_000b);
      msk = 11;
      ev(1'b1, 16'h0012);
      chk_pin(irq, 2'b00);
      ev(1'b0, 16'h0034);
      @(posedge clk);
      chk_pin(irq, 2'b01);
      rd(ADDR_STATUS, flg & ~msk);
      chk_pin(irq, 2'b00);
      rd(ADDR_RAW, 32'h0000_0000);
      wb(1'b1, ADDR_UPPER, 32'd100);
      wb(1'b1, ADDR_LOWER, -32'sd50);
      wb(1'b1, ADDR_MASK, 32'h0000_0007);
      wb(1'b1, ADDR_CTRL, 32'h0000_0001);
      up = 100;
      lo = -50;
      msk = 7;
      en = 1;
      for (int k = 0; k < 12; k++) begin
         v = k < 4 ? 16'(tbl[k]) : (k < 10 ? 16'($urandom_range(255) - 128) : 16'h0000);
         if (k == 10) begin
            wb(1'b1, ADDR_CTRL, 32'h0000_0000);
            en = 0;
         end
         ev(1'b0, v);
         @(posedge clk);
         chk_pin(irq, {1'b0, |(flg & ~msk & 13)});
         if (k % 2 == 1) rd(ADDR_RAW, flg);
      end
      // settle count passed three bypassed conversions, comparator now off
      rd(ADDR_CTRL, 32'h0000_0100);
      // calibration interrupt unmasked alone
      wb(1'b1, ADDR_MASK, 32'h0000_000e);
      msk = 14;
      ev(1'b1, 16'h0056);
      @(posedge clk);
      chk_pin(irq, {1'b0, |(flg & ~msk & 13)});
      rd(ADDR_STATUS, flg & ~msk);
      chk_pin(irq, 2'b00);
      for (int r = 0; r < 2; r++) begin
         wb(1'b1, ADDR_SETUP, 32'h0040_0000 | (32'(r) << RATE_BIT));
         n = 0;
         while (mclk !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
         end
         n = 0;
         while (mclk === 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
         end
         chk(n, r != 0 ? SLOW_HALF : FAST_HALF);
         chk_pin(moe_n, 2'b00);
         wb(1'b1, ADDR_SETUP, 32'h0000_0000);
      end
      repeat (3) @(posedge clk);
      chk_pin({moe_n, mclk}, 2'b10);
      stop_test;
   end
endmodule
